/* hdl/ipcd_top.sv */
// Input port with change detectors and interrupt aggregation.
// Assumes host bus pins are synchronous to clk at 250 MHz; input pins pass a two-flop synchroniser here.
`timescale 1ns/1ns
`include "ipcd_map.svh"

module ipcd_top
  import ipcd_pkg::*;
#(
  parameter int NUM_PINS = 7,
  parameter int NUM_WATCHED = 4,
  parameter int NUM_OTHER = 7,
  parameter int REF_DIV = `IPCD_REF_DIV,
  parameter int TAP_DIV = `IPCD_TAP_DIV
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cen_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] d_in,
  output logic [7:0] d_out,
  output logic d_oe,
  input wire logic [NUM_PINS-1:0] in_pins,
  input wire logic [NUM_OTHER-1:0] other_events,
  output logic [NUM_PINS-1:0] aux_pins,
  output logic change_of_state,
  output logic irq_out_n
);

  localparam int REF_W = $clog2(REF_DIV + 1);
  localparam int TAP_W = $clog2(TAP_DIV + 1);

  // Synchroniser stages
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;

  // Rate dividers
  logic [REF_W-1:0] ref_cnt;
  logic [TAP_W-1:0] tap_cnt;
  logic ref_tick;
  logic sample_tick;

  // Detector results
  logic [NUM_WATCHED-1:0] det_level;
  logic [NUM_WATCHED-1:0] det_change;

  // Software visible state
  logic [NUM_WATCHED-1:0] change_flags;
  logic [NUM_WATCHED-1:0] aux_control_reg;
  logic [7:0] irq_mask_reg;

  // Bus cycle tracking
  ipcd_bus_t bus_state;
  ipcd_bus_t next_bus_state;
  ipcd_addr_t cyc_addr;
  ipcd_byte_t wr_data;

  // Pins pass two flops before any use
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= in_pins;
      pin_sync <= pin_meta;
    end
  end

  // Pins offered to other internal logic
  always_ff @(posedge clk) begin
    if (srst) begin
      aux_pins <= '0;
    end else begin
      aux_pins <= pin_sync;
    end
  end

  // Reference rate enable standing in for the crystal clock
  wire logic ref_wrap;
  assign ref_wrap = (ref_cnt == REF_W'(REF_DIV - 1));

  always_ff @(posedge clk) begin
    if (srst) begin
      ref_cnt <= '0;
      ref_tick <= 1'b0;
    end else begin
      ref_cnt <= ref_wrap ? '0 : ref_cnt + 1'b1;
      ref_tick <= ref_wrap;
    end
  end

  // Divide reference by 96 for the detector sample strobe
  wire logic tap_wrap;
  assign tap_wrap = ref_tick && (tap_cnt == TAP_W'(TAP_DIV - 1));

  always_ff @(posedge clk) begin
    if (srst) begin
      tap_cnt <= '0;
    end else begin
      if (ref_tick) begin
        tap_cnt <= tap_wrap ? '0 : tap_cnt + 1'b1;
      end
    end
  end

  // Sample strobe, one clk cycle wide
  always_ff @(posedge clk) begin
    if (srst) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= tap_wrap;
    end
  end

  // One detector per watched pin, low pins only
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WATCHED; gi++) begin : g_det
      ipcd_detect u_det (
        .clk(clk),
        .srst(srst),
        .sample_en(sample_tick),
        .pin(pin_sync[gi]),
        .level(det_level[gi]),
        .changed(det_change[gi])
      );
    end
  endgenerate

  // Host bus decode
  wire logic rd_act;
  wire logic wr_act;
  assign rd_act = !cen_n && !rd_n;
  assign wr_act = !cen_n && !wr_n && rd_n;

  wire logic rd_end;
  wire logic wr_end;
  assign rd_end = (bus_state == IPCD_READ) && !rd_act;
  assign wr_end = (bus_state == IPCD_WRITE) && !wr_act;

  // Next bus cycle state
  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      IPCD_IDLE: begin
        if (rd_act) begin
          next_bus_state = IPCD_READ;
        end else if (wr_act) begin
          next_bus_state = IPCD_WRITE;
        end
      end
      IPCD_READ: begin
        if (!rd_act) begin
          next_bus_state = IPCD_IDLE;
        end
      end
      IPCD_WRITE: begin
        if (!wr_act) begin
          next_bus_state = IPCD_IDLE;
        end
      end
      default: begin
        next_bus_state = IPCD_IDLE;
      end
    endcase
  end

  // Bus cycle state
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_state <= IPCD_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Address follows the bus while idle and is frozen once a strobe is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      cyc_addr <= '0;
    end else begin
      if (bus_state == IPCD_IDLE) begin
        cyc_addr <= addr;
      end
    end
  end

  // Write data tracks the bus while the strobe stands; the last value is used
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_data <= '0;
    end else begin
      if (wr_act) begin
        wr_data <= d_in;
      end
    end
  end

  // Decode address: live bus in the first strobe cycle, held copy after,
  // so the first data beat of a read already belongs to the new address
  wire logic [3:0] dec_addr;
  assign dec_addr = (bus_state == IPCD_IDLE) ? addr : cyc_addr;

  // Register selects for the cycle in progress
  wire logic sel_port;
  wire logic sel_pcr;
  wire logic sel_isr;
  wire logic sel_mask_rd;
  wire logic sel_aux_rd;
  wire logic wr_acr;
  wire logic wr_imr;
  wire logic clr_flags;
  assign sel_port = (dec_addr == `IPCD_ADDR_INPUT_PORT);
  assign sel_pcr = (dec_addr == `IPCD_ADDR_PIN_CHANGE);
  assign sel_isr = (dec_addr == `IPCD_ADDR_IRQ_STATUS);
  assign sel_mask_rd = (dec_addr == `IPCD_ADDR_MASK_READ);
  assign sel_aux_rd = (dec_addr == `IPCD_ADDR_AUX_READ);
  assign wr_acr = wr_end && (cyc_addr == `IPCD_ADDR_AUX_CONTROL);
  assign wr_imr = wr_end && (cyc_addr == `IPCD_ADDR_IRQ_MASK);
  assign clr_flags = rd_end && sel_pcr;

  // Change flags: a new change wins over a clear in the same cycle
  wire logic [NUM_WATCHED-1:0] next_change_flags;
  assign next_change_flags = (change_flags & ~{NUM_WATCHED{clr_flags}}) | det_change;

  always_ff @(posedge clk) begin
    if (srst) begin
      change_flags <= '0;
    end else begin
      change_flags <= next_change_flags;
    end
  end

  // Per-pin change enables, written at the end of a write strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      aux_control_reg <= `IPCD_ACR_RST;
    end else begin
      if (wr_acr) begin
        aux_control_reg <= wr_data[NUM_WATCHED-1:0];
      end
    end
  end

  // Interrupt mask, written at the end of a write strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_mask_reg <= `IPCD_MASK_RST;
    end else begin
      if (wr_imr) begin
        irq_mask_reg <= wr_data;
      end
    end
  end

  // Interrupt conditions, change of state in the top bit only
  wire logic cos_cond;
  wire logic [7:0] irq_status_reg;
  wire logic [7:0] irq_active;
  assign cos_cond = |(change_flags & aux_control_reg);
  assign irq_status_reg = {cos_cond, other_events};
  assign irq_active = irq_status_reg & irq_mask_reg;

  // Read data sources
  wire logic [7:0] port_value;
  wire logic [7:0] pcr_value;
  wire logic [7:0] rd_mux;
  assign port_value = {1'b1, pin_sync};
  assign pcr_value = {change_flags, det_level};
  assign rd_mux = sel_port ? port_value :
                  sel_pcr ? pcr_value :
                  sel_isr ? irq_status_reg :
                  sel_mask_rd ? irq_mask_reg :
                  sel_aux_rd ? {4'h0, aux_control_reg} :
                  `IPCD_UNMAPPED_READ;

  // Drive the bus whenever the next cycle is a read
  wire logic drive_next;
  assign drive_next = (next_bus_state == IPCD_READ);

  // Output enable, high for every cycle of a read
  always_ff @(posedge clk) begin
    if (srst) begin
      d_oe <= 1'b0;
    end else begin
      d_oe <= drive_next;
    end
  end

  // Read data refreshed every cycle, zero when not reading
  always_ff @(posedge clk) begin
    if (srst) begin
      d_out <= '0;
    end else begin
      d_out <= drive_next ? rd_mux : 8'h00;
    end
  end

  // Interrupt output, negated as soon as its causes fall
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= !(|irq_active);
    end
  end

  // Change summary for other internal logic
  always_ff @(posedge clk) begin
    if (srst) begin
      change_of_state <= 1'b0;
    end else begin
      change_of_state <= cos_cond;
    end
  end

endmodule // ipcd_top

/* hdl/ipcd_map.svh */
// Constants for the input port change detector: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design modules.
// Operation
// - Port read returns present pin levels
// - Top data bit always reads one
// - Port never latches, reads live levels
// - Rise or fall on low four pins flags
// - Detectors sample on 38.4 kHz tap strobe
// - Two equal new samples confirm a change
// - Reading pin change register clears flags
// - Enabled change raises interrupt request
// - Aux control bits enable per-pin change interrupts
// - Status shows change occurred, not which pin
// - Single active-low interrupt from eight conditions
// - Mask selects which conditions drive interrupt
// - Status read returns all active conditions
// - Pins also routed to internal logic
// - Pin change read negates change interrupt
// - Clearing mask bit negates its interrupt
`ifndef IPCD_MAP_SVH
`define IPCD_MAP_SVH

// Register offsets on the four-bit address
`define IPCD_ADDR_PIN_CHANGE 4'h4
`define IPCD_ADDR_AUX_CONTROL 4'h4
`define IPCD_ADDR_IRQ_STATUS 4'h5
`define IPCD_ADDR_IRQ_MASK 4'h5
`define IPCD_ADDR_MASK_READ 4'h6
`define IPCD_ADDR_AUX_READ 4'h7
`define IPCD_ADDR_INPUT_PORT 4'hd

// Field positions
`define IPCD_TOP_DATA_BIT 7
`define IPCD_ISR_COS_BIT 7
`define IPCD_PCR_FLAG_LSB 4

// Reset values
`define IPCD_MASK_RST 8'h00
`define IPCD_ACR_RST 4'h0
`define IPCD_UNMAPPED_READ 8'h00

// Timing: reference clock, tap division, guaranteed hold window
`define IPCD_CLK_PERIOD_PS 4000
`define IPCD_XTAL_PERIOD_PS 271267
`define IPCD_REF_DIV ((`IPCD_XTAL_PERIOD_PS + `IPCD_CLK_PERIOD_PS / 2) / `IPCD_CLK_PERIOD_PS)
`define IPCD_TAP_DIV 96
`define IPCD_HOLD_MIN_US 25
`define IPCD_HOLD_MAX_US 50

`endif

/* hdl/ipcd_pkg.sv */
// Types shared by the input port change detector modules.
// Assumes the map header sits beside it under hdl/.
`include "ipcd_map.svh"

package ipcd_pkg;

  // Host bus cycle in progress
  typedef enum logic [1:0] {
    IPCD_IDLE,
    IPCD_READ,
    IPCD_WRITE
  } ipcd_bus_t;

  typedef logic [7:0] ipcd_byte_t;
  typedef logic [3:0] ipcd_addr_t;

endpackage

/* hdl/ipcd_detect.sv */
// One change-of-state detector for a single synchronised pin.
// Assumes the pin is already in the clk domain and sample_en is a one-cycle pulse.
`timescale 1ns/1ns

module ipcd_detect (
  input wire logic clk,
  input wire logic srst,
  input wire logic sample_en,
  input wire logic pin,
  output logic level,
  output logic changed
);

  logic prev_sample;
  logic primed;
  wire logic confirm;

  // Two successive samples agree and differ from the accepted level
  assign confirm = primed && (pin == prev_sample) && (pin != level);

  // Sample history and accepted level
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_sample <= 1'b0;
      primed <= 1'b0;
      level <= 1'b0;
      changed <= 1'b0;
    end else begin
      changed <= 1'b0;
      if (sample_en) begin
        prev_sample <= pin;
        if (!primed) begin
          // First sample after reset sets the baseline, no flag
          primed <= 1'b1;
          level <= pin;
        end else if (confirm) begin
          level <= pin;
          changed <= 1'b1;
        end
      end
    end
  end

endmodule // ipcd_detect

/* verification/ipcd_top_asserts.sv */
// Port-level checks for the input port with change detectors.
// Assumes binding onto ipcd_top; one clock, synchronous reset.
`timescale 1ns/1ns
module ipcd_top_chk #(
  parameter int NUM_PINS = 7,
  parameter int NUM_OTHER = 7
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cen_n,
  input wire logic rd_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] d_out,
  input wire logic d_oe,
  input wire logic [NUM_PINS-1:0] in_pins,
  input wire logic [NUM_OTHER-1:0] other_events,
  input wire logic [NUM_PINS-1:0] aux_pins,
  input wire logic change_of_state,
  input wire logic irq_out_n
);
  logic [3:0] taken;
  logic [1:0] up;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Read start, address of the cycle, cycles since reset
  sequence s_take;
    !cen_n && !rd_n && !d_oe;
  endsequence
  always_ff @(posedge clk) begin
    if (srst) begin
      taken <= 4'h0;
      up <= 2'h0;
    end else begin
      if (!cen_n && !rd_n && !d_oe) taken <= addr;
      if (up != 2'h3) up <= up + 2'h1;
    end
  end
  chk_read_drives: assert property (s_take |=> d_oe) else $error("no drive");
  chk_read_holds: assert property (!cen_n && !rd_n && d_oe |=> d_oe)
    else $error("drive lost");
  chk_release_drop: assert property (d_oe && rd_n |=> !d_oe) else $error("late float");
  chk_idle_zero: assert property (!d_oe |-> d_out == 8'h00) else $error("idle data");
  chk_top_bit: assert property (d_oe && taken == 4'hd |-> d_out[7])
    else $error("top bit low");
  chk_aux_route: assert property (up == 2'h3 |-> aux_pins == $past(in_pins, 3))
    else $error("aux pins");
  chk_cos_clear: assert property (d_oe && rd_n && taken == 4'h4
    |-> ##[1:3] !change_of_state) else $error("flags kept");
  chk_irq_gone: assert property ($fell(change_of_state) && other_events == 0
    |-> ##[0:2] irq_out_n) else $error("irq held");
endmodule // ipcd_top_chk

/* verification/ipcd_host.sv */
// Host processor model on the parallel read/write bus.
// Assumes clk is the block clock; drives just after rising edges.
`timescale 1ns/1ns
module ipcd_host (
  input wire logic clk,
  output logic cen_n,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] addr,
  output logic [7:0] d_in,
  input wire logic [7:0] d_out
);
  initial begin
    cen_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 4'h0;
    d_in = 8'h00;
  end
  // Read: strobe held, data taken at last edge, released lines scrambled
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 cen_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    repeat (3) @(posedge clk);
    v = d_out;
    #1 rd_n = 1'b1;
    cen_n = 1'b1;
    addr = ~a;
    repeat (2) @(posedge clk);
  endtask
  // Write: data held through strobe, idle gap after
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 cen_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    d_in = v;
    repeat (2) @(posedge clk);
    #1 wr_n = 1'b1;
    cen_n = 1'b1;
    addr = ~a;
    d_in = ~v;
    repeat (3) @(posedge clk);
  endtask
endmodule // ipcd_host

/* verification/testbench.sv */
// Self-checking bench for the input port with change detectors.
// Assumes short sampling divisors so a sample falls every 6 clocks.
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [6:0] in_pins = 7'h55;
  logic [6:0] other_events = 7'h00;
  wire cen_n, rd_n, wr_n, d_oe, change_of_state, irq_out_n;
  wire [3:0] addr;
  wire [7:0] d_in, d_out;
  wire [6:0] aux_pins;
  int n_errors = 0;
  int checks = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  ipcd_host host (.clk(clk), .cen_n(cen_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .d_in(d_in), .d_out(d_out));
  ipcd_top #(.REF_DIV(2), .TAP_DIV(3)) dut (.clk(clk), .srst(srst), .cen_n(cen_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
    .in_pins(in_pins), .other_events(other_events), .aux_pins(aux_pins),
    .change_of_state(change_of_state), .irq_out_n(irq_out_n));
  // Compare and count
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    cmp(v, exp);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence; pin levels held 40 clocks per change, the glitch 6
  initial begin
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    rdc(4'hd, 8'hd5);
    rdc(4'h6, 8'h00);
    rdc(4'h7, 8'h00);
    rdc(4'h0, 8'h00);
    rdc(4'h4, 8'h05);
    host.wr(4'h4, 8'h01);
    host.wr(4'h5, 8'h80);
    rdc(4'h7, 8'h01);
    rdc(4'h6, 8'h80);
    #1 in_pins = 7'h2a;
    repeat (40) @(posedge clk);
    cmp({7'h00, irq_out_n}, 8'h00);
    rdc(4'hd, 8'haa);
    rdc(4'h5, 8'h80);
    rdc(4'h4, 8'hfa);
    repeat (3) @(posedge clk);
    cmp({7'h00, irq_out_n}, 8'h01);
    rdc(4'h4, 8'h0a);
    // Glitch one sample period long on a watched pin: seen by one sample only
    #1 in_pins = 7'h28;
    repeat (6) @(posedge clk);
    #1 in_pins = 7'h6a;
    repeat (40) @(posedge clk);
    rdc(4'h4, 8'h0a);
    #1 other_events = 7'h01;
    host.wr(4'h5, 8'h01);
    cmp({7'h00, irq_out_n}, 8'h00);
    rdc(4'h5, 8'h01);
    host.wr(4'h5, 8'h00);
    cmp({7'h00, irq_out_n}, 8'h01);
    summarize();
  end
endmodule // testbench
bind ipcd_top ipcd_top_chk #(.NUM_PINS(NUM_PINS), .NUM_OTHER(NUM_OTHER)) u_chk (.clk(clk),
  .srst(srst), .cen_n(cen_n), .rd_n(rd_n), .addr(addr), .d_out(d_out), .d_oe(d_oe),
  .in_pins(in_pins), .other_events(other_events), .aux_pins(aux_pins),
  .change_of_state(change_of_state), .irq_out_n(irq_out_n));
